// ===== dv/codec_serial_port_bench.sv
`timescale 1ns/1ps
`default_nettype none
module codec_serial_port_bench;
  import codec_port_pkg::*;
  logic        clk_sys = 1'b0, rst = 1'b1, pe_req = 1'b1, port_enable = 1'b0;
  logic        sample_tick = 1'b0, adc_valid = 1'b0;
  logic [15:0] adc_data = 16'h0000;
  logic        adc_ready, bit_clock, output_data_line, output_frame_pulse;
  logic        input_data_line, input_frame_pulse, dac_valid, ctrl_valid;
  logic        converting, soft_reset, ok;
  logic [15:0] ctrl_word, a, b, d;
  conv_word_t  dac_word;
  conv_word_t  dac_q[$];
  logic [15:0] exp_q[$];
  int          error_cnt = 0, checks_done = 0, cyc = 0, srst_cnt = 0, n;
  codec_serial_port codec_serial_port_i (.clk_sys, .rst, .port_enable,
    .sample_tick, .adc_data, .adc_valid, .adc_ready, .bit_clock,
    .output_data_line, .output_frame_pulse, .input_data_line,
    .input_frame_pulse, .dac_word, .dac_valid, .ctrl_word, .ctrl_valid,
    .converting, .soft_reset);
  host_port_model host_port_model_i (.bit_clock, .output_data_line,
    .output_frame_pulse, .input_data_line, .input_frame_pulse);
  initial forever #2.5 clk_sys = ~clk_sys;
  // Enable passes a flop, as a cascade would need
  always @(posedge clk_sys) port_enable <= pe_req;
  // Collect strobes and cut a hang short
  always @(posedge clk_sys) begin
    if (dac_valid === 1'b1) dac_q.push_back(dac_word);
    if (soft_reset === 1'b1) srst_cnt++;
    if (++cyc == 20000) begin
      error_cnt++;
      $display("Error timeout expected done seen running");
      results();
    end
  end
  task chk(input string what, input logic [16:0] seen,
           input logic [16:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task results;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  function automatic logic [15:0] cw(input logic st, input logic sr);
    cw = 16'h0000;
    cw[CTRL_FLAG_POS] = 1'b1;
    cw[CTRL_START_POS] = st;
    cw[CTRL_SRESET_POS] = sr;
  endfunction
  // Offer one word; ready seen before the edge that takes it
  task push(input logic [15:0] w);
    @(posedge clk_sys) adc_data <= w;
    adc_valid <= 1'b1;
    #1 ok = adc_ready;
    @(posedge clk_sys) adc_valid <= 1'b0;
    if (ok) exp_q.push_back(w);
  endtask
  task tick;
    @(posedge clk_sys) sample_tick <= 1'b1;
    @(posedge clk_sys) sample_tick <= 1'b0;
  endtask
  initial begin
    void'($urandom(16));
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk("converting", converting, 17'h0);
    chk("adc_ready", adc_ready, 17'h1);
    tick();
    repeat (400) @(posedge clk_sys);
    n = host_port_model_i.rx_q.size();
    chk("frames before start", 17'(n), 17'h0);
    $display("reset test done");
    // Fill until the buffer refuses
    n = 0;
    do begin
      push(16'($urandom));
      n += int'(ok);
    end while (ok);
    chk("fifo depth", 17'(n), 17'(FIFO_DEPTH));
    host_port_model_i.send(cw(1'b1, 1'b0));
    repeat (20) @(posedge clk_sys);
    chk("ctrl_word", ctrl_word, cw(1'b1, 1'b0));
    chk("converting", converting, 17'h1);
    $display("fill and start test done");
    // Mixed periods: control word first, then two converter words
    for (int p = 0; p < 3; p++) begin
      host_port_model_i.rx_q.delete();
      dac_q.delete();
      tick();
      a = 16'($urandom) & 16'h7FFF;
      b = 16'($urandom) & 16'h7FFF;
      host_port_model_i.send(cw(1'b1, 1'b0));
      host_port_model_i.send(a);
      host_port_model_i.send(b);
      while (host_port_model_i.rx_q.size() < 2) @(posedge clk_sys);
      repeat (10) @(posedge clk_sys);
      chk("tx word0", host_port_model_i.rx_q[0], exp_q.pop_front());
      chk("tx word1", host_port_model_i.rx_q[1], exp_q.pop_front());
      chk("dac count", 17'(dac_q.size()), 17'h2);
      chk("dac0", dac_q[0], {1'b0, a});
      chk("dac1", dac_q[1], {1'b1, b});
      push(16'($urandom));
      push(16'($urandom));
    end
    $display("period test done");
    pe_req <= 1'b0;
    repeat (10) @(posedge clk_sys);
    host_port_model_i.rx_q.delete();
    tick();
    repeat (300) @(posedge clk_sys);
    chk("bit_clock", bit_clock, 17'h0);
    chk("frames off", 17'(host_port_model_i.rx_q.size()), 17'h0);
    pe_req <= 1'b1;
    repeat (500) @(posedge clk_sys);
    $display("enable test done");
    // Start and soft reset together: the reset wins
    srst_cnt = 0;
    host_port_model_i.send(cw(1'b1, 1'b1));
    repeat (20) @(posedge clk_sys);
    chk("soft_reset", 17'(srst_cnt), 17'h1);
    chk("converting", converting, 17'h0);
    $display("soft reset test done");
    results();
  end
endmodule
`default_nettype wire

// ===== dv/codec_serial_port_props.sv
`timescale 1ns/1ps
`default_nettype none
module codec_serial_port_props
  import codec_port_pkg::*;
#(
  parameter int SCLK_HALF = SCLK_HALF_CYCLES
) (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        port_enable,
  input wire logic        bit_clock,
  input wire logic        output_data_line,
  input wire logic        output_frame_pulse,
  input wire logic        dac_valid,
  input wire logic [15:0] ctrl_word,
  input wire logic        ctrl_valid,
  input wire logic        converting,
  input wire logic        soft_reset
);
  localparam int PER_M1  = 2 * SCLK_HALF - 1;
  localparam int HALF_M1 = SCLK_HALF - 1;
  localparam int WORD_CY = WORD_BITS * 2 * SCLK_HALF;
  logic [15:0] gap_ff;
  logic [15:0] nxt_gap;
  // Saturating count of cycles since a frame was last high
  assign nxt_gap = output_frame_pulse ? 16'h0000 :
                   (gap_ff == 16'hFFFF) ? gap_ff : gap_ff + 16'h0001;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) gap_ff <= 16'hFFFF;
    else gap_ff <= nxt_gap;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Frame steps: high for one bit period, then low
  sequence frame_period;
    ##PER_M1 output_frame_pulse ##1 !output_frame_pulse;
  endsequence
  sequence start_seen;
    ##[0:2] (ctrl_word[CTRL_FLAG_POS] && ctrl_word[CTRL_START_POS]);
  endsequence
  a_frame_width: assert property (
    $rose(output_frame_pulse) |-> frame_period)
    else $error("frame pulse not one bit period");
  a_frame_on_rise: assert property (
    $rose(output_frame_pulse) |-> $rose(bit_clock))
    else $error("frame pulse not on a bit clock rise");
  a_word_gap: assert property (
    $rose(output_frame_pulse) |-> gap_ff >= WORD_CY)
    else $error("frame before sixteen bits sent");
  a_data_on_rise: assert property (
    $changed(output_data_line) |-> $rose(bit_clock))
    else $error("data changed off a bit clock rise");
  // Disabled port may cut a half period short
  a_clock_half: assert property (
    @(posedge clk_sys) disable iff (rst || !port_enable)
    $rose(bit_clock) |-> ##HALF_M1 bit_clock ##1 !bit_clock)
    else $error("bit clock half period wrong");
  a_idle_off: assert property (
    !port_enable [*4] |=> !bit_clock && !output_frame_pulse)
    else $error("port active while disabled");
  a_dac_gated: assert property (dac_valid |-> converting)
    else $error("converter word before start");
  a_start_word: assert property ($rose(converting) |-> start_seen)
    else $error("conversion started without start word");
  a_soft_reset: assert property (
    soft_reset |-> ##[0:2] (!converting && ctrl_word[CTRL_SRESET_POS]))
    else $error("soft reset left conversion running");
  a_single_pulse: assert property (
    (dac_valid || ctrl_valid) |=> !(dac_valid || ctrl_valid))
    else $error("word strobe longer than one cycle");
endmodule
bind codec_serial_port codec_serial_port_props #(
  .SCLK_HALF (SCLK_HALF)
) codec_serial_port_props_i (
  .clk_sys            (clk_sys),
  .rst                (rst),
  .port_enable        (port_enable),
  .bit_clock          (bit_clock),
  .output_data_line   (output_data_line),
  .output_frame_pulse (output_frame_pulse),
  .dac_valid          (dac_valid),
  .ctrl_word          (ctrl_word),
  .ctrl_valid         (ctrl_valid),
  .converting         (converting),
  .soft_reset         (soft_reset)
);
`default_nettype wire

// ===== dv/host_port_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_port_model (
  input  wire logic bit_clock,
  input  wire logic output_data_line,
  input  wire logic output_frame_pulse,
  output logic      input_data_line,
  output logic      input_frame_pulse
);
  logic [15:0] rx_q[$];
  logic [15:0] sh = 16'h0000;
  int          left = 0;
  initial begin
    input_data_line = 1'b0;
    input_frame_pulse = 1'b0;
  end
  // Frame one clock ahead of the MSB; changes on the rise
  task automatic send(input logic [15:0] w);
    @(posedge bit_clock) input_frame_pulse <= 1'b1;
    for (int i = 15; i >= 0; i--) begin
      @(posedge bit_clock) input_frame_pulse <= 1'b0;
      input_data_line <= w[i];
    end
    // Inverse after the word so a stale bit cannot pass as data
    @(posedge bit_clock) input_data_line <= ~w[0];
  endtask
  // Sample on the fall, sixteen bits after each frame
  always @(negedge bit_clock) begin
    if (left > 0) begin
      sh = {sh[14:0], output_data_line};
      left = left - 1;
      if (left == 0) rx_q.push_back(sh);
    end else if (output_frame_pulse) left = 16;
  end
endmodule
`default_nettype wire

// ===== rtl/codec_port_pkg.sv
package codec_port_pkg;

  // Link word geometry
  localparam int WORD_BITS        = 16;
  localparam int WORDS_PER_PERIOD = 2;
  localparam int MAX_CASCADE      = 4;
  localparam int MAX_FWD_WORDS    = WORDS_PER_PERIOD * (MAX_CASCADE - 1);

  // Bit clock: half period in clk_sys cycles (200 MHz system clock)
  localparam int SYS_CLK_MHZ      = 200;
  localparam int SCLK_HALF_NS     = 25;
  localparam int SCLK_HALF_CYCLES = (SCLK_HALF_NS * SYS_CLK_MHZ + 999) / 1000;

  // Control word fields
  localparam int CTRL_FLAG_POS    = 15;
  localparam int CTRL_START_POS   = 8;
  localparam int CTRL_SRESET_POS  = 7;

  // Reset values
  localparam logic [15:0] SAMPLE_RESET = 16'h0000;
  localparam int          FIFO_DEPTH   = 8;

  // One word as it travels on the serial link
  typedef struct packed {
    logic        ctrl;
    logic [14:0] body;
  } link_word_t;

  // Converter word handed to the user side
  typedef struct packed {
    logic        chan;
    logic [15:0] data;
  } conv_word_t;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_FRAME = 2'b01,
    TX_SHIFT = 2'b10
  } tx_state_t;

endpackage

// ===== rtl/codec_serial_port.sv
`timescale 1ns/1ps
`default_nettype none
module codec_serial_port
  import codec_port_pkg::*;
#(
  parameter int SCLK_HALF = SCLK_HALF_CYCLES,
  parameter int FDEPTH    = FIFO_DEPTH
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        port_enable,
  input  wire logic        sample_tick,
  input  wire logic [15:0] adc_data,
  input  wire logic        adc_valid,
  output logic             adc_ready,
  output logic             bit_clock,
  output logic             output_data_line,
  output logic             output_frame_pulse,
  input  wire logic        input_data_line,
  input  wire logic        input_frame_pulse,
  output conv_word_t       dac_word,
  output logic             dac_valid,
  output logic [15:0]      ctrl_word,
  output logic             ctrl_valid,
  output logic             converting,
  output logic             soft_reset
);
  localparam int DW = $clog2(SCLK_HALF + 1);
  // Pin synchronisers
  logic pe_s1_ff, pe_s2_ff;
  logic din_s1_ff, din_s2_ff;
  logic dfs_s1_ff, dfs_s2_ff;
  // Bit clock divider
  logic [DW-1:0] div_ff;
  logic          sclk_ff;
  // Transmit side
  tx_state_t     tx_state_ff;
  link_word_t    tx_sh_ff;
  logic [3:0]    tx_cnt_ff;
  logic          dout_ff;
  logic          fs_out_ff;
  logic [1:0]    own_left_ff;
  link_word_t    fwd_word_ff;
  logic          fwd_full_ff;
  logic [2:0]    fwd_cnt_ff;
  // Receive side
  logic          rx_act_ff;
  logic [3:0]    rx_cnt_ff;
  logic [14:0]   rx_sh_ff;
  logic [1:0]    dac_cnt_ff;
  logic          run_ff;
  logic          srst_ff;
  conv_word_t    dac_word_ff;
  logic          dac_valid_ff;
  logic [15:0]   ctrl_word_ff;
  logic          ctrl_valid_ff;
  // FIFO read side
  wire [15:0]    fifo_data;
  wire           fifo_valid;
  // Edge decode of our own bit clock; it only toggles while enabled
  wire           pe_on     = pe_s2_ff;
  wire           div_done  = (div_ff == DW'(SCLK_HALF - 1));
  wire           toggle    = pe_on && div_done;
  wire           sclk_rise = toggle && !sclk_ff;
  wire           sclk_fall = toggle && sclk_ff;
  // Transmit source selection: own samples first, then forwarded words
  wire           tx_start  = sclk_rise && (tx_state_ff == TX_IDLE);
  wire           own_go    = tx_start && (own_left_ff != 2'd0);
  wire           fwd_go    = tx_start && !own_go && fwd_full_ff;
  wire           fifo_pop  = own_go && fifo_valid;
  wire [15:0]    own_word  = fifo_valid ? fifo_data : SAMPLE_RESET;
  wire           tx_last   = (tx_cnt_ff == 4'd15);
  // Receive word completion and classification
  wire           rx_done   = sclk_fall && rx_act_ff && (rx_cnt_ff == 4'd15);
  wire [15:0]    rx_word   = {rx_sh_ff, din_s2_ff};
  wire           rx_ctrl   = rx_word[CTRL_FLAG_POS];
  wire           rx_start  = rx_done && rx_ctrl && rx_word[CTRL_START_POS];
  wire           rx_sreset = rx_done && rx_ctrl && rx_word[CTRL_SRESET_POS];
  wire           rx_dac    = rx_done && !rx_ctrl && run_ff &&
                             (dac_cnt_ff != 2'(WORDS_PER_PERIOD));
  wire           rx_fwd    = rx_done && !rx_ctrl && !rx_dac &&
                             (fwd_cnt_ff != 3'(MAX_FWD_WORDS));
  sample_fifo #(
    .WIDTH (WORD_BITS),
    .DEPTH (FDEPTH)
  ) u_adc_fifo (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .wr_data  (adc_data),
    .wr_valid (adc_valid),
    .wr_ready (adc_ready),
    .rd_data  (fifo_data),
    .rd_valid (fifo_valid),
    .rd_ready (fifo_pop)
  );

  assign bit_clock          = sclk_ff;
  assign output_data_line   = dout_ff;
  assign output_frame_pulse = fs_out_ff;
  assign dac_word           = dac_word_ff;
  assign dac_valid          = dac_valid_ff;
  assign ctrl_word          = ctrl_word_ff;
  assign ctrl_valid         = ctrl_valid_ff;
  assign converting         = run_ff;
  assign soft_reset         = srst_ff;

  // Two flops on the enable and serial input pins before any logic looks at them
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pe_s1_ff  <= 1'b0;
      pe_s2_ff  <= 1'b0;
      din_s1_ff <= 1'b0;
      din_s2_ff <= 1'b0;
      dfs_s1_ff <= 1'b0;
      dfs_s2_ff <= 1'b0;
    end else begin
      pe_s1_ff  <= port_enable;
      pe_s2_ff  <= pe_s1_ff;
      din_s1_ff <= input_data_line;
      din_s2_ff <= din_s1_ff;
      dfs_s1_ff <= input_frame_pulse;
      dfs_s2_ff <= dfs_s1_ff;
    end
  end

  // Divider depends only on reset and enable, so chained codecs keep phase
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div_ff  <= '0;
      sclk_ff <= 1'b0;
    end else if (!pe_on) begin
      div_ff  <= '0;
      sclk_ff <= 1'b0;
    end else begin
      div_ff  <= div_done ? '0 : div_ff + 1'b1;
      sclk_ff <= sclk_ff ^ div_done;
    end
  end

  // Transmit state machine; outputs change on bit clock rising edges
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tx_state_ff <= TX_IDLE;
      tx_sh_ff    <= '0;
      tx_cnt_ff   <= '0;
      dout_ff     <= 1'b0;
      fs_out_ff   <= 1'b0;
    end else if (!pe_on) begin
      tx_state_ff <= TX_IDLE;
      dout_ff     <= 1'b0;
      fs_out_ff   <= 1'b0;
    end else if (sclk_rise) begin
      unique case (tx_state_ff)
        TX_IDLE: begin
          dout_ff <= 1'b0;
          if (own_go || fwd_go) begin
            tx_sh_ff    <= own_go ? link_word_t'(own_word) : fwd_word_ff;
            fs_out_ff   <= 1'b1;
            tx_state_ff <= TX_FRAME;
          end
        end
        TX_FRAME: begin
          fs_out_ff   <= 1'b0;
          dout_ff     <= tx_sh_ff[15];
          tx_sh_ff    <= {tx_sh_ff[14:0], 1'b0};
          tx_cnt_ff   <= 4'd0;               // 15 more bits follow
          tx_state_ff <= TX_SHIFT;
        end
        TX_SHIFT: begin
          if (tx_last) begin
            dout_ff     <= 1'b0;
            tx_state_ff <= TX_IDLE;
          end else begin
            dout_ff   <= tx_sh_ff[15];
            tx_sh_ff  <= {tx_sh_ff[14:0], 1'b0};
            tx_cnt_ff <= tx_cnt_ff + 1'b1;
          end
        end
      endcase
    end
  end

  // Per period budget: two own samples, empty FIFO sends invalid zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      own_left_ff <= '0;
      dac_cnt_ff  <= '0;
      fwd_cnt_ff  <= '0;
    end else if (rx_sreset) begin
      own_left_ff <= '0;
      dac_cnt_ff  <= '0;
      fwd_cnt_ff  <= '0;
    end else if (sample_tick && run_ff) begin
      own_left_ff <= 2'(WORDS_PER_PERIOD);
      dac_cnt_ff  <= '0;
      fwd_cnt_ff  <= '0;
    end else begin
      if (own_go) begin
        own_left_ff <= own_left_ff - 1'b1;
      end
      if (rx_dac) begin
        dac_cnt_ff <= dac_cnt_ff + 1'b1;
      end
      if (rx_fwd) begin
        fwd_cnt_ff <= fwd_cnt_ff + 1'b1;
      end
    end
  end

  // Words beyond our own two pass down the chain after our samples
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fwd_word_ff <= '0;
      fwd_full_ff <= 1'b0;
    end else if (rx_fwd) begin
      fwd_word_ff <= link_word_t'(rx_word);
      fwd_full_ff <= 1'b1;
    end else if (fwd_go || !pe_on) begin
      fwd_full_ff <= 1'b0;
    end
  end

  // Shift in on bit clock falls; frame in last bit starts next word
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_act_ff <= 1'b0;
      rx_cnt_ff <= '0;
      rx_sh_ff  <= '0;
    end else if (!pe_on) begin
      rx_act_ff <= 1'b0;
    end else if (sclk_fall) begin
      if ((!rx_act_ff || rx_done) && dfs_s2_ff) begin
        rx_act_ff <= 1'b1;
        rx_cnt_ff <= '0;
      end else if (rx_act_ff) begin
        rx_sh_ff  <= {rx_sh_ff[13:0], din_s2_ff};
        rx_cnt_ff <= rx_cnt_ff + 1'b1;
        rx_act_ff <= !rx_done;
      end
    end
  end

  // Control mode after reset; a start control word begins conversion
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      run_ff  <= 1'b0;
      srst_ff <= 1'b0;
    end else begin
      srst_ff <= rx_sreset;
      if (rx_sreset) begin
        run_ff <= 1'b0;
      end else if (rx_start) begin
        run_ff <= 1'b1;
      end
    end
  end

  // Received words to user side as one cycle pulses
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dac_word_ff   <= '0;
      dac_valid_ff  <= 1'b0;
      ctrl_word_ff  <= '0;
      ctrl_valid_ff <= 1'b0;
    end else begin
      dac_valid_ff  <= rx_dac;
      ctrl_valid_ff <= rx_done && rx_ctrl;
      if (rx_dac) begin
        dac_word_ff <= '{chan: dac_cnt_ff[0], data: rx_word};
      end
      if (rx_done && rx_ctrl) begin
        ctrl_word_ff <= rx_word;
      end
    end
  end

endmodule
`default_nettype wire

// ===== rtl/sample_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module sample_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  output logic      [WIDTH-1:0] rd_data,
  output logic                  rd_valid,
  input  wire logic             rd_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  wire              push;
  wire              pop;

  // Honest flags: full and empty come straight from the word count
  assign wr_ready = (count_ff != (AW+1)'(DEPTH));
  assign rd_valid = (count_ff != '0);
  assign push     = wr_valid && wr_ready;
  assign pop      = rd_valid && rd_ready;
  assign rd_data  = mem[rd_ptr_ff];

  // Pointers wrap at DEPTH so non power of two depths still work
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end

  // Storage has no reset; contents are only read behind rd_valid
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr_ff] <= wr_data;
    end
  end

endmodule

`default_nettype wire
